// [hdl/fel_regs.svh]
/*
  constants of the fault escalation and lockup unit: register offsets,
  field positions, reset values and fixed priorities.
  assumes an 8-bit word-aligned register address and 32-bit data.
*/
// Operation
// - bus error on fetch, vector load or data access raises a fault
// - executing from an execute-never region raises a fault
// - executing with the state bit clear raises a fault, vector bit 0 too
// - with protection on, privilege or unmanaged access gives protection fault
// - bus error on vector read is severe and sets the vector read flag
// - an escalated fault sets the escalated flag in severe status
// - protection mismatches set instruction, data, stacking or unstacking flags
// - execute-never access sets instruction violation even without protection
// - bus errors set stacking, unstacking, prefetch, exact or deferred flags
// - usage fault flags: coprocessor, undefined, state, return, unaligned, divide
// - bad state covers foreign instruction sets and bad continuation return
// - configurable faults have software priority and enable; severe is fixed
// - escalate on same or lower priority fault in handler or disabled handler
// - escalate any fault not above the running exception priority
// - bus error pushing the bus fault entry frame does not escalate
// - severe preempts all but reset, non-maskable and severe
// - data protection faults and exact data bus errors capture the faulting address
// - fault in non-maskable or severe handler enters lockup
// - lockup ends only by reset, non-maskable interrupt or debug halt
// - lockup from the non-maskable handler ignores later non-maskable interrupts
// - reset, non-maskable and severe hold fixed negative priorities
// - equal priority never preempts; it is marked pending
`ifndef FEL_REGS_SVH
`define FEL_REGS_SVH

`define FEL_ADDR_W        8
`define FEL_OFF_CTRL      8'h00
`define FEL_OFF_PRIO      8'h04
`define FEL_OFF_SEV_ST    8'h08
`define FEL_OFF_PROT_ST   8'h0C
`define FEL_OFF_BUS_ST    8'h10
`define FEL_OFF_USE_ST    8'h14
`define FEL_OFF_PROT_ADDR 8'h18
`define FEL_OFF_BUS_ADDR  8'h1C
`define FEL_OFF_STATE     8'h20

`define FEL_CTRL_W        4
`define FEL_CTRL_RST      4'h0
`define FEL_CTRL_PROT_EN  0
`define FEL_CTRL_BUS_EN   1
`define FEL_CTRL_USE_EN   2
`define FEL_CTRL_PROT_ON  3

`define FEL_PRIO_W        24
`define FEL_PRIO_RST      24'h000000
`define FEL_PRIO_PROT_LSB 0
`define FEL_PRIO_BUS_LSB  8
`define FEL_PRIO_USE_LSB  16

`define FEL_FIX_RESET     10'h3FD
`define FEL_FIX_NMI       10'h3FE
`define FEL_FIX_SEVERE    10'h3FF
`define FEL_FIX_THREAD    10'h100

`define FEL_SEV_W         2
`define FEL_PROT_W        4
`define FEL_BUS_W         5
`define FEL_USE_W         6
`define FEL_SEV_VECT      0
`define FEL_SEV_ESC       1

`endif

// [hdl/fel_pkg.sv]
/*
  types of the fault escalation and lockup unit.
  assumes fel_regs.svh is available on the include path.
*/
package fel_pkg;
  typedef logic signed [9:0] fel_prio_type;

  typedef enum logic [3:0] {
    FC_NONE   = 4'h0,
    FC_SEVERE = 4'h1,
    FC_PROT   = 4'h2,
    FC_BUS    = 4'h4,
    FC_USAGE  = 4'h8
  } fel_class_type;

  typedef enum logic [2:0] {
    LK_RUN = 3'h1,
    LK_SEV = 3'h2,
    LK_NMI = 3'h4
  } fel_lock_type;

  // smaller number wins; equal never preempts
  function automatic logic fel_higher(input fel_prio_type a, input fel_prio_type b);
    fel_higher = (a < b);
  endfunction : fel_higher
endpackage : fel_pkg

// [hdl/fel_sticky_flags.sv]
/*
  bank of sticky cause flags with write-one-to-clear.
  assumes set and clear are synchronous single-cycle terms.
*/
module fel_sticky_flags
  import fel_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output logic      [W-1:0] flags_o
);
  // set beats clear so a fresh cause is never lost
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_o <= '0;
    end else begin
      flags_o <= (flags_o & ~clr_i) | set_i;
    end
  end
endmodule : fel_sticky_flags

// [hdl/fel_fault_unit.sv]
/*
  fault detection, classification, escalation, address capture and lockup.
  assumes all inputs are synchronous single-cycle event or level signals
  from pipeline, bus and protection unit, and a plain register port master.
*/
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "fel_regs.svh"

module fel_fault_unit
  import fel_pkg::*;
(
  input  wire logic                   SYS_CLK_I,
  input  wire logic                   RSTN_I,
  input  wire logic [`FEL_ADDR_W-1:0] ADDR_I,
  input  wire logic [31:0]            WDATA_I,
  input  wire logic                   WE_I,
  input  wire logic                   RE_I,
  output logic      [31:0]            RDATA_O,
  input  wire logic                   FETCH_BUS_ERR_I,
  input  wire logic                   VECT_BUS_ERR_I,
  input  wire logic                   DATA_BUS_ERR_I,
  input  wire logic                   DATA_BUS_ERR_DEFER_I,
  input  wire logic                   STACK_BUS_ERR_I,
  input  wire logic                   UNSTACK_BUS_ERR_I,
  input  wire logic                   BUS_ENTRY_PUSH_I,
  input  wire logic                   FETCH_EXEC_NEVER_I,
  input  wire logic                   FETCH_PROT_VIOL_I,
  input  wire logic                   DATA_PROT_VIOL_I,
  input  wire logic                   STACK_PROT_VIOL_I,
  input  wire logic                   UNSTACK_PROT_VIOL_I,
  input  wire logic [31:0]            FAULT_ADDR_I,
  input  wire logic                   EXEC_STATE_CLEAR_I,
  input  wire logic                   VECT_LOADED_I,
  input  wire logic                   VECT_ENTRY_LSB_I,
  input  wire logic                   FOREIGN_ISA_I,
  input  wire logic                   CONT_RETURN_BAD_I,
  input  wire logic                   COPROC_ACCESS_I,
  input  wire logic                   UNDEF_OPCODE_I,
  input  wire logic                   BAD_RETURN_CODE_I,
  input  wire logic                   UNALIGNED_I,
  input  wire logic                   ZERO_DIVIDE_I,
  input  wire logic                   IN_HANDLER_I,
  input  wire logic                   IN_NMI_I,
  input  wire logic                   IN_SEVERE_I,
  input  wire logic [7:0]             CUR_PRIO_I,
  input  wire logic                   NMI_I,
  input  wire logic                   DBG_HALT_I,
  output logic                        FAULT_VALID_O,
  output logic      [3:0]             FAULT_CLASS_O,
  output logic                        FAULT_ESCALATED_O,
  output logic      [9:0]             FAULT_PRIO_O,
  output logic                        FAULT_PREEMPT_O,
  output logic                        FAULT_PEND_O,
  output logic                        LOCKUP_O
);

  logic [`FEL_CTRL_W-1:0] ctrl_r;
  logic [`FEL_PRIO_W-1:0] prio_r;
  logic [31:0]            prot_addr_r;
  logic [31:0]            bus_addr_r;
  fel_lock_type           lock_r;
  fel_lock_type           lock_nxt;

  logic [`FEL_SEV_W-1:0]  sev_set;
  logic [`FEL_SEV_W-1:0]  sev_clr;
  logic [`FEL_SEV_W-1:0]  sev_flags;
  logic [`FEL_PROT_W-1:0] prot_set;
  logic [`FEL_PROT_W-1:0] prot_clr;
  logic [`FEL_PROT_W-1:0] prot_flags;
  logic [`FEL_BUS_W-1:0]  bus_set;
  logic [`FEL_BUS_W-1:0]  bus_clr;
  logic [`FEL_BUS_W-1:0]  bus_flags;
  logic [`FEL_USE_W-1:0]  use_set;
  logic [`FEL_USE_W-1:0]  use_clr;
  logic [`FEL_USE_W-1:0]  use_flags;

  logic                   prot_on;
  logic                   bad_state;
  logic                   any_fault;
  logic                   lock_hit;
  logic                   report;
  logic                   escalate;
  logic                   preempt;
  logic                   cls_en;
  fel_class_type          cls;
  fel_prio_type           cls_prio;
  fel_prio_type           cur_prio;
  fel_prio_type           eff_prio;

  // address decode for every register write; reads decode in their own case
  function automatic logic hit(input logic [`FEL_ADDR_W-1:0] a,
                               input logic [`FEL_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic fel_prio_type cfg_prio(input logic [7:0] p);
    cfg_prio = fel_prio_type'({2'b00, p});
  endfunction : cfg_prio

  // fault sources
  assign prot_on = ctrl_r[`FEL_CTRL_PROT_ON];

  assign prot_set = {
    UNSTACK_PROT_VIOL_I & prot_on,
    STACK_PROT_VIOL_I & prot_on,
    DATA_PROT_VIOL_I & prot_on,
    (FETCH_PROT_VIOL_I & prot_on) | FETCH_EXEC_NEVER_I
  };

  assign bus_set = {
    DATA_BUS_ERR_DEFER_I,
    DATA_BUS_ERR_I,
    FETCH_BUS_ERR_I,
    UNSTACK_BUS_ERR_I,
    STACK_BUS_ERR_I
  };

  // a vector entry with a clear low bit leaves the state bit clear
  assign bad_state = EXEC_STATE_CLEAR_I
                   | (VECT_LOADED_I & ~VECT_ENTRY_LSB_I)
                   | FOREIGN_ISA_I
                   | CONT_RETURN_BAD_I;

  assign use_set = {
    ZERO_DIVIDE_I,
    UNALIGNED_I,
    BAD_RETURN_CODE_I,
    bad_state,
    UNDEF_OPCODE_I,
    COPROC_ACCESS_I
  };

  assign any_fault = VECT_BUS_ERR_I | (|prot_set) | (|bus_set) | (|use_set);

  // class pick for simultaneous causes; the others are still flagged
  always_comb begin
    cls      = FC_NONE;
    cls_prio = `FEL_FIX_SEVERE;
    cls_en   = 1'b1;
    if (VECT_BUS_ERR_I) begin
      cls = FC_SEVERE;
    end else if (|prot_set) begin
      cls      = FC_PROT;
      cls_prio = cfg_prio(prio_r[`FEL_PRIO_PROT_LSB +: 8]);
      cls_en   = ctrl_r[`FEL_CTRL_PROT_EN];
    end else if (|bus_set) begin
      cls      = FC_BUS;
      cls_prio = cfg_prio(prio_r[`FEL_PRIO_BUS_LSB +: 8]);
      cls_en   = ctrl_r[`FEL_CTRL_BUS_EN];
    end else if (|use_set) begin
      cls      = FC_USAGE;
      cls_prio = cfg_prio(prio_r[`FEL_PRIO_USE_LSB +: 8]);
      cls_en   = ctrl_r[`FEL_CTRL_USE_EN];
    end
  end

  // priority of what runs now; thread mode sits below every handler
  always_comb begin
    if (IN_NMI_I) begin
      cur_prio = `FEL_FIX_NMI;
    end else if (IN_SEVERE_I) begin
      cur_prio = `FEL_FIX_SEVERE;
    end else if (IN_HANDLER_I) begin
      cur_prio = cfg_prio(CUR_PRIO_I);
    end else begin
      cur_prio = `FEL_FIX_THREAD;
    end
  end

  // escalation of a configurable class
  always_comb begin
    escalate = 1'b0;
    if (cls != FC_SEVERE && cls != FC_NONE) begin
      escalate = !cls_en
               || !fel_higher(cls_prio, cur_prio);
      if (cls == FC_BUS && BUS_ENTRY_PUSH_I) begin
        escalate = 1'b0;
      end
    end
  end

  assign eff_prio = (cls == FC_SEVERE || escalate) ? fel_prio_type'(`FEL_FIX_SEVERE)
                                                    : cls_prio;

  // strictly smaller wins, so an equal level only pends
  assign preempt = fel_higher(eff_prio, cur_prio);

  assign lock_hit = any_fault && (IN_NMI_I || IN_SEVERE_I) && lock_r == LK_RUN;
  assign report   = any_fault && !lock_hit && lock_r == LK_RUN;

  assign sev_set = {report & escalate, VECT_BUS_ERR_I};

  // write one to clear on the status words
  assign sev_clr  = (WE_I && hit(ADDR_I, `FEL_OFF_SEV_ST))  ? WDATA_I[`FEL_SEV_W-1:0]  : '0;
  assign prot_clr = (WE_I && hit(ADDR_I, `FEL_OFF_PROT_ST)) ? WDATA_I[`FEL_PROT_W-1:0] : '0;
  assign bus_clr  = (WE_I && hit(ADDR_I, `FEL_OFF_BUS_ST))  ? WDATA_I[`FEL_BUS_W-1:0]  : '0;
  assign use_clr  = (WE_I && hit(ADDR_I, `FEL_OFF_USE_ST))  ? WDATA_I[`FEL_USE_W-1:0]  : '0;

  fel_sticky_flags #(.W(`FEL_SEV_W)) u_sev_flags (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RSTN_I),
    .set_i   (sev_set),
    .clr_i   (sev_clr),
    .flags_o (sev_flags)
  );

  fel_sticky_flags #(.W(`FEL_PROT_W)) u_prot_flags (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RSTN_I),
    .set_i   (prot_set),
    .clr_i   (prot_clr),
    .flags_o (prot_flags)
  );

  fel_sticky_flags #(.W(`FEL_BUS_W)) u_bus_flags (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RSTN_I),
    .set_i   (bus_set),
    .clr_i   (bus_clr),
    .flags_o (bus_flags)
  );

  fel_sticky_flags #(.W(`FEL_USE_W)) u_use_flags (
    .clk_i   (SYS_CLK_I),
    .rstn_i  (RSTN_I),
    .set_i   (use_set),
    .clr_i   (use_clr),
    .flags_o (use_flags)
  );

  // control register; handlers start disabled
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl_r <= `FEL_CTRL_RST;
    end else if (WE_I && hit(ADDR_I, `FEL_OFF_CTRL)) begin
      ctrl_r <= WDATA_I[`FEL_CTRL_W-1:0];
    end
  end

  // priority register; severe keeps its fixed level outside it
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prio_r <= `FEL_PRIO_RST;
    end else if (WE_I && hit(ADDR_I, `FEL_OFF_PRIO)) begin
      prio_r <= WDATA_I[`FEL_PRIO_W-1:0];
    end
  end

  // address capture; a newer fault overwrites the older address
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      prot_addr_r <= 32'h00000000;
    end else if (DATA_PROT_VIOL_I && prot_on) begin
      prot_addr_r <= FAULT_ADDR_I;
    end
  end

  // deferred errors carry no usable address, so only exact ones land
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bus_addr_r <= 32'h00000000;
    end else if (DATA_BUS_ERR_I) begin
      bus_addr_r <= FAULT_ADDR_I;
    end
  end

  // lockup state
  always_comb begin
    lock_nxt = lock_r;
    case (lock_r)
      LK_RUN: begin
        if (lock_hit) begin
          lock_nxt = IN_NMI_I ? LK_NMI : LK_SEV;
        end
      end
      LK_SEV: begin
        if (NMI_I || DBG_HALT_I) begin
          lock_nxt = LK_RUN;
        end
      end
      LK_NMI: begin
        if (DBG_HALT_I) begin
          lock_nxt = LK_RUN;
        end
      end
      default: begin
        lock_nxt = LK_RUN;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      lock_r   <= LK_RUN;
      LOCKUP_O <= 1'b0;
    end else begin
      lock_r   <= lock_nxt;
      LOCKUP_O <= (lock_nxt != LK_RUN);
    end
  end

  // fault report towards exception prioritisation
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      FAULT_VALID_O     <= 1'b0;
      FAULT_CLASS_O     <= FC_NONE;
      FAULT_ESCALATED_O <= 1'b0;
      FAULT_PRIO_O      <= 10'h000;
      FAULT_PREEMPT_O   <= 1'b0;
      FAULT_PEND_O      <= 1'b0;
    end else begin
      FAULT_VALID_O     <= report;
      FAULT_CLASS_O     <= report ? (escalate ? FC_SEVERE : cls) : FC_NONE;
      FAULT_ESCALATED_O <= report & escalate;
      FAULT_PRIO_O      <= report ? eff_prio : 10'h000;
      FAULT_PREEMPT_O   <= report & preempt;
      FAULT_PEND_O      <= report & !preempt;
    end
  end

  // read port; data only in the cycle after the strobe
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= 32'h00000000;
    end else if (RE_I) begin
      case (ADDR_I)
        `FEL_OFF_CTRL:      RDATA_O <= 32'(ctrl_r);
        `FEL_OFF_PRIO:      RDATA_O <= 32'(prio_r);
        `FEL_OFF_SEV_ST:    RDATA_O <= 32'(sev_flags);
        `FEL_OFF_PROT_ST:   RDATA_O <= 32'(prot_flags);
        `FEL_OFF_BUS_ST:    RDATA_O <= 32'(bus_flags);
        `FEL_OFF_USE_ST:    RDATA_O <= 32'(use_flags);
        `FEL_OFF_PROT_ADDR: RDATA_O <= prot_addr_r;
        `FEL_OFF_BUS_ADDR:  RDATA_O <= bus_addr_r;
        `FEL_OFF_STATE:     RDATA_O <= 32'(lock_r);
        default:            RDATA_O <= 32'h00000000;
      endcase
    end else begin
      RDATA_O <= 32'h00000000;
    end
  end

endmodule : fel_fault_unit

// [verification/fel_cpu_model.sv]
/*
  behavioural pipeline, bus and protection side of the fault unit:
  turns a request mask into one-cycle cause pulses and a fault address.
  assumes the bench raises fire_i for one cycle per event.
*/
module fel_cpu_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        fire_i,
  input  wire logic [21:0] req_i,
  input  wire logic [31:0] addr_i,
  output logic      [21:0] cause_o,
  output logic      [31:0] addr_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // bits 20 and 21 carry the non-maskable interrupt and the debug halt
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cause_o <= 22'h000000;
      addr_o  <= 32'h00000000;
    end else if (fire_i) begin
      cause_o <= req_i;
      addr_o  <= addr_i;
    end else begin
      cause_o <= 22'h000000;
      // address is only good in its cycle: invert it every idle cycle, so the inverse and the old value alternate
      addr_o  <= ~addr_o;
    end
  end
endmodule : fel_cpu_model

// [verification/fel_fault_unit_checker.sv]
/*
  concurrent checks on the fault unit ports.
  assumes one clock domain and an asynchronous active-low reset.
*/
module fel_fault_unit_checker (
  input wire logic       SYS_CLK_I,
  input wire logic       RSTN_I,
  input wire logic       VECT_BUS_ERR_I,
  input wire logic       UNDEF_OPCODE_I,
  input wire logic       IN_HANDLER_I,
  input wire logic       IN_NMI_I,
  input wire logic       IN_SEVERE_I,
  input wire logic [7:0] CUR_PRIO_I,
  input wire logic       NMI_I,
  input wire logic       DBG_HALT_I,
  input wire logic       FAULT_VALID_O,
  input wire logic [3:0] FAULT_CLASS_O,
  input wire logic       FAULT_ESCALATED_O,
  input wire logic [9:0] FAULT_PRIO_O,
  input wire logic       FAULT_PREEMPT_O,
  input wire logic       FAULT_PEND_O,
  input wire logic       LOCKUP_O
);
  timeunit 1ns;
  timeprecision 100ps;

  logic nmi_src_r;

  // frozen while locked, so it keeps the context of the locking fault
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      nmi_src_r <= 1'h0;
    end else if (!LOCKUP_O) begin
      nmi_src_r <= IN_NMI_I;
    end
  end

  default clocking dc @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  AST_VECT_SEVERE: assert property (VECT_BUS_ERR_I && !LOCKUP_O && !IN_NMI_I && !IN_SEVERE_I
    |=> FAULT_VALID_O && FAULT_CLASS_O == 4'h1) else $error("vector error not severe");
  AST_ESC_SEVERE: assert property (FAULT_ESCALATED_O
    |-> FAULT_VALID_O && FAULT_CLASS_O == 4'h1 && FAULT_PRIO_O == 10'h3FF)
    else $error("escalation not reported as severe");
  AST_SEVERE_PREEMPT: assert property (FAULT_VALID_O && FAULT_CLASS_O == 4'h1
    |-> FAULT_PREEMPT_O && FAULT_PRIO_O == 10'h3FF) else $error("severe fault not preempting");
  AST_LOCK_ENTER: assert property (UNDEF_OPCODE_I && (IN_NMI_I || IN_SEVERE_I) && !LOCKUP_O
    && !NMI_I && !DBG_HALT_I |=> LOCKUP_O && !FAULT_VALID_O) else $error("no lockup");
  AST_LOCK_HOLD: assert property (LOCKUP_O && !NMI_I && !DBG_HALT_I |=> LOCKUP_O)
    else $error("lockup left without cause");
  AST_NMI_EXIT: assert property (LOCKUP_O && NMI_I && !DBG_HALT_I && !nmi_src_r
    |=> !LOCKUP_O) else $error("nmi did not end lockup");
  AST_NMI_NO_EXIT: assert property (LOCKUP_O && NMI_I && !DBG_HALT_I && nmi_src_r
    |=> LOCKUP_O) else $error("nmi ended lockup taken in nmi handler");
  AST_DBG_EXIT: assert property (LOCKUP_O && DBG_HALT_I |=> !LOCKUP_O)
    else $error("debug halt did not end lockup");
  AST_NO_REPORT_LOCKED: assert property (LOCKUP_O |=> !FAULT_VALID_O)
    else $error("fault reported while locked");
  AST_PREEMPT_XOR: assert property (FAULT_VALID_O |-> FAULT_PREEMPT_O != FAULT_PEND_O)
    else $error("preempt and pend not exclusive");
  AST_NOT_ABOVE: assert property (FAULT_VALID_O && !FAULT_ESCALATED_O && FAULT_CLASS_O != 4'h1
    && $past(IN_HANDLER_I) |-> FAULT_PREEMPT_O
    == ($signed(FAULT_PRIO_O) < $signed({2'h0, $past(CUR_PRIO_I)})))
    else $error("preemption disagrees with priority");

  cover property (FAULT_ESCALATED_O);
  cover property (FAULT_VALID_O && FAULT_PEND_O);
  cover property (LOCKUP_O && NMI_I && nmi_src_r);
  cover property (LOCKUP_O && DBG_HALT_I);
endmodule : fel_fault_unit_checker

// [verification/fel_fault_unit_tb.sv]
/*
  self-checking bench of the fault unit, causes come from the pipeline model.
  assumes register read data one cycle after the strobe and fault reports
  one cycle after the cause.
*/
`include "fel_regs.svh"

module fel_fault_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        we = 1'h0;
  logic        re = 1'h0;
  logic        fire = 1'h0;
  logic [21:0] req = 22'h0;
  logic [31:0] faddr = 32'h0;
  logic        lsb = 1'h1, push = 1'h0, inh = 1'h0, innmi = 1'h0, insev = 1'h0;
  logic [7:0]  cprio = 8'h00;
  logic [21:0] c;
  logic [31:0] fa, rdata;
  logic        fv, fe, fpre, fpend, lock;
  logic [3:0]  fc;
  logic [9:0]  fp;
  int          err_count = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;

  fel_cpu_model fel_cpu_model_inst (.clk_i(clk), .rstn_i(rstn), .fire_i(fire), .req_i(req),
    .addr_i(faddr), .cause_o(c), .addr_o(fa));

  fel_fault_unit fel_fault_unit_inst (
    .SYS_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata), .WE_I(we), .RE_I(re),
    .RDATA_O(rdata), .FETCH_BUS_ERR_I(c[0]), .VECT_BUS_ERR_I(c[1]), .DATA_BUS_ERR_I(c[2]),
    .DATA_BUS_ERR_DEFER_I(c[3]), .STACK_BUS_ERR_I(c[4]), .UNSTACK_BUS_ERR_I(c[5]),
    .BUS_ENTRY_PUSH_I(push), .FETCH_EXEC_NEVER_I(c[6]), .FETCH_PROT_VIOL_I(c[7]),
    .DATA_PROT_VIOL_I(c[8]), .STACK_PROT_VIOL_I(c[9]), .UNSTACK_PROT_VIOL_I(c[10]),
    .FAULT_ADDR_I(fa), .EXEC_STATE_CLEAR_I(c[11]), .VECT_LOADED_I(c[12]),
    .VECT_ENTRY_LSB_I(lsb), .FOREIGN_ISA_I(c[13]), .CONT_RETURN_BAD_I(c[14]),
    .COPROC_ACCESS_I(c[15]), .UNDEF_OPCODE_I(c[16]), .BAD_RETURN_CODE_I(c[17]),
    .UNALIGNED_I(c[18]), .ZERO_DIVIDE_I(c[19]), .IN_HANDLER_I(inh), .IN_NMI_I(innmi),
    .IN_SEVERE_I(insev), .CUR_PRIO_I(cprio), .NMI_I(c[20]), .DBG_HALT_I(c[21]),
    .FAULT_VALID_O(fv), .FAULT_CLASS_O(fc), .FAULT_ESCALATED_O(fe), .FAULT_PRIO_O(fp),
    .FAULT_PREEMPT_O(fpre), .FAULT_PEND_O(fpend), .LOCKUP_O(lock));

  task automatic give_verdict;
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: value %h, expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk_flt(input logic [18:0] exp);
    cmp_count++;
    if ({fv, fc, fe, fp, fpre, fpend, lock} !== exp) begin
      err_count++;
      $display("Error %0t: fault report %h, expected %h", $time,
               {fv, fc, fe, fp, fpre, fpend, lock}, exp);
    end
  endtask : chk_flt

  // expected report: valid, class, escalated, priority, preempt, pend, unlocked
  function automatic logic [18:0] ef(input logic [3:0] cl, input logic [9:0] pr,
                                     input logic es, input logic pe);
    ef = {1'h1, cl, es, pr, pe, !pe, 1'h0};
  endfunction : ef

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'h1;
    @(posedge clk);
    we    <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    re   <= 1'h1;
    @(posedge clk);
    re   <= 1'h0;
    #1;
    chk32(rdata, exp);
  endtask : rd

  // levels: {vector lsb, entry push, in handler, in nmi, in severe}
  task automatic ctx(input logic [4:0] lv, input logic [7:0] p);
    @(posedge clk);
    {lsb, push, inh, innmi, insev} <= lv;
    cprio <= p;
  endtask : ctx

  // one cause cycle from the model, returns where the report is settled
  task automatic evt(input logic [21:0] m, input logic [31:0] a = 32'h0);
    @(posedge clk);
    req   <= m;
    faddr <= a;
    fire  <= 1'h1;
    @(posedge clk);
    fire  <= 1'h0;
    @(posedge clk);
    #1;
  endtask : evt

  task automatic t_reset;
    rd(`FEL_OFF_CTRL, 32'h0);
    rd(`FEL_OFF_PRIO, 32'h0);
    rd(`FEL_OFF_STATE, 32'h1);
    rd(`FEL_OFF_SEV_ST, 32'h0);
    rd(8'h24, 32'h0);
    wr(`FEL_OFF_BUS_ADDR, 32'hFFFFFFFF);
    rd(`FEL_OFF_BUS_ADDR, 32'h0);
  endtask : t_reset

  task automatic t_usage;
    int          src [9] = '{15, 16, 13, 14, 17, 18, 19, 11, 12};
    int          flg [9] = '{0, 1, 2, 2, 3, 4, 5, 2, 2};
    logic [31:0] acc;
    acc = 32'h0;
    wr(`FEL_OFF_CTRL, 32'h4);
    wr(`FEL_OFF_PRIO, 32'h50000);
    rd(`FEL_OFF_PRIO, 32'h50000);
    ctx(5'h00, 8'h00);
    for (int i = 0; i < 9; i++) begin
      evt(22'h1 << src[i]);
      chk_flt(ef(4'h8, 10'h005, 1'h0, 1'h1));
      acc[flg[i]] = 1'h1;
      rd(`FEL_OFF_USE_ST, acc);
    end
    wr(`FEL_OFF_USE_ST, 32'h3F);
    rd(`FEL_OFF_USE_ST, 32'h0);
  endtask : t_usage

  task automatic t_faults;
    int src [9] = '{7, 8, 9, 10, 4, 5, 0, 2, 3};
    wr(`FEL_OFF_CTRL, 32'h7);
    wr(`FEL_OFF_PRIO, 32'h50302);
    ctx(5'h10, 8'h00);
    evt(22'h100);
    chk32({30'h0, fv, lock}, 32'h0);
    evt(22'h40);
    chk_flt(ef(4'h2, 10'h002, 1'h0, 1'h1));
    rd(`FEL_OFF_PROT_ST, 32'h1);
    wr(`FEL_OFF_CTRL, 32'hF);
    for (int i = 0; i < 9; i++) begin
      evt(22'h1 << src[i], 32'h10000000 + 32'(i));
      if (i < 4) begin
        chk_flt(ef(4'h2, 10'h002, 1'h0, 1'h1));
        rd(`FEL_OFF_PROT_ST, (32'h2 << i) - 32'h1);
      end else begin
        chk_flt(ef(4'h4, 10'h003, 1'h0, 1'h1));
        rd(`FEL_OFF_BUS_ST, (32'h2 << (i - 4)) - 32'h1);
      end
    end
    rd(`FEL_OFF_PROT_ADDR, 32'h10000001);
    rd(`FEL_OFF_BUS_ADDR, 32'h10000007);
    wr(`FEL_OFF_PROT_ST, 32'hF);
    rd(`FEL_OFF_PROT_ST, 32'h0);
    wr(`FEL_OFF_BUS_ST, 32'h1F);
    rd(`FEL_OFF_BUS_ST, 32'h0);
  endtask : t_faults

  task automatic t_severe;
    evt(22'h2);
    chk_flt(ef(4'h1, 10'h3FF, 1'h0, 1'h1));
    rd(`FEL_OFF_SEV_ST, 32'h1);
    // usage handler off: must escalate
    wr(`FEL_OFF_CTRL, 32'hB);
    evt(22'h10000);
    chk_flt(ef(4'h1, 10'h3FF, 1'h1, 1'h1));
    rd(`FEL_OFF_SEV_ST, 32'h3);
    wr(`FEL_OFF_CTRL, 32'hF);
    ctx(5'h14, 8'h05);
    evt(22'h10000);
    chk_flt(ef(4'h1, 10'h3FF, 1'h1, 1'h1));
    ctx(5'h14, 8'h06);
    evt(22'h10000);
    chk_flt(ef(4'h8, 10'h005, 1'h0, 1'h1));
    ctx(5'h1C, 8'h03);
    evt(22'h10);
    chk_flt(ef(4'h4, 10'h003, 1'h0, 1'h0));
    ctx(5'h14, 8'h00);
    evt(22'h2);
    chk_flt(ef(4'h1, 10'h3FF, 1'h0, 1'h1));
    wr(`FEL_OFF_SEV_ST, 32'h3);
    rd(`FEL_OFF_SEV_ST, 32'h0);
  endtask : t_severe

  task automatic t_lock;
    ctx(5'h11, 8'h00);
    evt(22'h10000);
    chk32({30'h0, fv, lock}, 32'h1);
    rd(`FEL_OFF_STATE, 32'h2);
    evt(22'h80000);
    chk32({30'h0, fv, lock}, 32'h1);
    ctx(5'h10, 8'h00);
    evt(22'h100000);
    chk32({30'h0, fv, lock}, 32'h0);
    ctx(5'h12, 8'h00);
    evt(22'h10000);
    chk32({30'h0, fv, lock}, 32'h1);
    rd(`FEL_OFF_STATE, 32'h4);
    ctx(5'h10, 8'h00);
    evt(22'h100000);
    chk32({30'h0, fv, lock}, 32'h1);
    evt(22'h200000);
    chk32({30'h0, fv, lock}, 32'h0);
    rd(`FEL_OFF_STATE, 32'h1);
  endtask : t_lock

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    t_reset;
    t_usage;
    t_faults;
    t_severe;
    t_lock;
    give_verdict;
  end

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict;
  end
endmodule : fel_fault_unit_tb

bind fel_fault_unit fel_fault_unit_checker fel_fault_unit_checker_inst (
  .SYS_CLK_I, .RSTN_I, .VECT_BUS_ERR_I, .UNDEF_OPCODE_I, .IN_HANDLER_I, .IN_NMI_I,
  .IN_SEVERE_I, .CUR_PRIO_I, .NMI_I, .DBG_HALT_I, .FAULT_VALID_O, .FAULT_CLASS_O,
  .FAULT_ESCALATED_O, .FAULT_PRIO_O, .FAULT_PREEMPT_O, .FAULT_PEND_O, .LOCKUP_O);
